//--- ide_pkg.sv
/*
  Shared constants, types and encodings of the increment/divide execution block.
  Assumes a single clock domain and an 8-bit data / 16-bit address memory bus.
*/
`default_nettype none
package ide_pkg;
  // opcodes
  localparam logic [7:0] OP_IDIV = 8'h02;
  localparam logic [7:0] OP_INC_ACC_A = 8'h4C;
  localparam logic [7:0] OP_INC_ACC_B = 8'h5C;
  localparam logic [7:0] OP_INCE = 8'h7C;
  localparam logic [7:0] OP_INCX = 8'h6C;
  localparam logic [7:0] OP_PRE  = 8'h18;
  localparam logic [7:0] OP_INC_SP = 8'h31;
  // bus cycle counts
  localparam int         IDIV_LAST = 41;
  localparam logic [5:0] ACC_LAST  = 6'h02;
  localparam logic [5:0] INS_LAST  = 6'h03;
  localparam logic [5:0] MEM_LAST  = 6'h06;
  localparam logic [5:0] YMEM_LAST = 6'h07;
  // instruction lengths in bytes
  localparam logic [15:0] LEN_INH = 16'h0001;
  localparam logic [15:0] LEN_IDX = 16'h0002;
  localparam logic [15:0] LEN_EXT = 16'h0003;
  localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
  localparam logic [15:0] DIV_ZERO_Q = 16'hFFFF;
  localparam logic [7:0]  OVF_OPERAND = 8'h7F;
  // condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  // register offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_ACC  = 12'h008;
  localparam logic [11:0] ADDR_COND = 12'h00C;
  localparam logic [11:0] ADDR_X    = 12'h010;
  localparam logic [11:0] ADDR_Y    = 12'h014;
  localparam logic [11:0] ADDR_SP   = 12'h018;
  localparam logic [11:0] ADDR_PC   = 12'h01C;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILL  = 1;
  // reset values
  localparam logic [7:0]  RST_COND = 8'h00;
  localparam logic [15:0] RST_PC  = 16'h0000;
  localparam logic [15:0] RST_SP  = 16'h0000;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rw;
  } ide_bus_s;

  typedef enum logic {ST_IDLE, ST_EXEC} ide_state_e;
endpackage
`default_nettype wire

//--- ide_core.sv
/*
  Execution core for accumulator/memory increment, integer divide and stack
  pointer increment, with an APB slave for control and register access.
  Assumes memory returns read data combinationally within the bus cycle.
*/
// Notes on behaviour
// - divide D by X, quotient X, remainder D
// - increment adds one, stores back in place
// - accumulator and memory increments update N, Z, V only; stack increment none
// - increment never changes the carry flag
// - N is result bit 7, Z when zero
// - V set only when operand was 7F
// - accumulator increments 4C/5C take two cycles
// - memory forms write result last cycle, rw low
// - indexed 6C: X plus offset, dummies 3,5
// - stack increment 31, third cycle addresses SP
`timescale 1ns/100ps
`default_nettype none
module ide_core #(
  parameter int DIV_LAST = ide_pkg::IDIV_LAST
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // memory bus
  output ide_pkg::ide_bus_s      mem_o,
  output logic                   mem_active,
  input  wire logic [7:0]        mem_rdata
);
  generate
    if (DIV_LAST < 3 || DIV_LAST > 63) begin : g_bad_div
      $error("DIV_LAST must lie in 3..63");
    end
  endgenerate

  function automatic ide_pkg::ide_bus_s bus_of(input logic [15:0] a, input logic [7:0] d,
                                               input logic rw);
    ide_pkg::ide_bus_s b;
    b.addr = a;
    b.data = d;
    b.rw   = rw;
    return b;
  endfunction

  // new condition codes after incrementing v
  function automatic logic [7:0] cond_inc(input logic [7:0] cc, input logic [7:0] v);
    logic [7:0] r;
    logic [7:0] o;
    r = v + 8'h01;
    o = cc;
    o[ide_pkg::CC_N] = r[7];
    o[ide_pkg::CC_Z] = (r == 8'h00);
    o[ide_pkg::CC_V] = (v == ide_pkg::OVF_OPERAND);
    return o;
  endfunction

  ide_pkg::ide_state_e state_r;
  ide_pkg::ide_bus_s   bus_r;
  ide_pkg::ide_bus_s   nxt_bus;
  logic [5:0]          cyc_r;
  logic [7:0]          op_r;
  logic                pre_r;
  logic [15:0]         base_r;
  logic [7:0]          hb_r;
  logic [7:0]          lb_r;
  logic [7:0]          res_r;
  logic                act_r;
  logic [7:0]          a_r;
  logic [7:0]          b_r;
  logic [7:0]          condition_code_register;
  logic [15:0]         x_r;
  logic [15:0]         y_r;
  logic [15:0]         sp_r;
  logic [15:0]         pc_r;
  logic                run_r;
  logic                ill_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic [31:0]         rd_val;

  // sequencing
  wire logic        ex      = (state_r == ide_pkg::ST_EXEC);
  wire logic        idle_w  = (state_r == ide_pkg::ST_IDLE);
  wire logic [5:0]  cyc_n   = cyc_r + 6'h01;
  wire logic [5:0]  e_cur   = cyc_r - {5'h00, pre_r};
  wire logic [5:0]  e_n     = cyc_n - {5'h00, pre_r};
  wire logic        is_ext  = (op_r == ide_pkg::OP_INCE) && !pre_r;
  wire logic        is_idx  = (op_r == ide_pkg::OP_INCX);
  wire logic        mem_op  = is_ext || is_idx;
  wire logic        acc_a_increment_op = (op_r == ide_pkg::OP_INC_ACC_A) && !pre_r;
  wire logic        acc_b_increment_op = (op_r == ide_pkg::OP_INC_ACC_B) && !pre_r;
  wire logic        stack_pointer_increment_op = (op_r == ide_pkg::OP_INC_SP) && !pre_r;
  wire logic        div_op  = (op_r == ide_pkg::OP_IDIV) && !pre_r;
  wire logic        legal_op = (mem_rdata == ide_pkg::OP_IDIV)
                            || (mem_rdata == ide_pkg::OP_INC_ACC_A)
                            || (mem_rdata == ide_pkg::OP_INC_ACC_B)
                            || (mem_rdata == ide_pkg::OP_INCE) || (mem_rdata == ide_pkg::OP_INCX)
                            || (mem_rdata == ide_pkg::OP_PRE) || (mem_rdata == ide_pkg::OP_INC_SP);
  wire logic        halt_w  = ex && ((cyc_r == 6'h01 && !legal_op)
                            || (cyc_r == 6'h02 && pre_r && mem_rdata != ide_pkg::OP_INCX));
  wire logic [5:0]  last_w  = pre_r ? ide_pkg::YMEM_LAST :
                              div_op ? 6'(DIV_LAST) :
                              stack_pointer_increment_op ? ide_pkg::INS_LAST :
                              mem_op ? ide_pkg::MEM_LAST : ide_pkg::ACC_LAST;
  wire logic        done_w  = ex && !halt_w && cyc_r >= 6'h02 && cyc_r == last_w;
  wire logic [15:0] instr_len = (pre_r || is_ext) ? ide_pkg::LEN_EXT :
                                is_idx ? ide_pkg::LEN_IDX : ide_pkg::LEN_INH;
  wire logic [15:0] pc_next = base_r + instr_len;
  wire logic [15:0] fetch_a = base_r + {10'h000, cyc_r};
  wire logic [7:0]  ea_lo   = (is_ext && e_cur == 6'h03) ? mem_rdata : lb_r;
  wire logic [15:0] ea      = is_ext ? {hb_r, ea_lo} :
                              ((pre_r ? y_r : x_r) + {8'h00, lb_r});
  wire logic        mem_rd  = ex && mem_op && e_cur == 6'h04;
  // divide
  wire logic [15:0] dividend = {a_r, b_r};
  wire logic [15:0] quot    = (x_r == 16'h0000) ? ide_pkg::DIV_ZERO_Q : dividend / x_r;
  wire logic [15:0] rem     = (x_r == 16'h0000) ? dividend : dividend % x_r;
  // apb decode
  wire logic        acc_w   = psel && penable && !pready_r;
  wire logic        wr_w    = psel && penable && pwrite && pready_r;
  wire logic        hit     = (paddr[1:0] == 2'b00) && (paddr <= ide_pkg::ADDR_PC);
  wire logic        wr_cpu  = wr_w && idle_w;

  // address, data and direction of the next bus cycle
  always_comb begin
    nxt_bus = bus_of(ide_pkg::DUMMY_ADDR, 8'h00, 1'b1);
    if (cyc_n == 6'h02 || (pre_r && cyc_n == 6'h03) || (is_ext && e_n == 6'h03)) begin
      nxt_bus = bus_of(fetch_a, 8'h00, 1'b1);
    end else if (stack_pointer_increment_op) begin
      nxt_bus = bus_of(sp_r, 8'h00, 1'b1);
    end else if (mem_op && e_n == 6'h04) begin
      nxt_bus = bus_of(ea, 8'h00, 1'b1);
    end else if (mem_op && e_n == 6'h06) begin
      nxt_bus = bus_of(ea, res_r, 1'b0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ide_pkg::ST_IDLE;
      cyc_r   <= 6'h00;
      op_r    <= 8'h00;
      pre_r   <= 1'b0;
      base_r  <= 16'h0000;
      hb_r    <= 8'h00;
      lb_r    <= 8'h00;
      res_r   <= 8'h00;
      act_r   <= 1'b0;
      bus_r   <= '{addr: ide_pkg::DUMMY_ADDR, data: 8'h00, rw: 1'b1};
    end else if (idle_w || halt_w || done_w) begin
      cyc_r <= 6'h01;
      pre_r <= 1'b0;
      if (run_r && !halt_w) begin
        state_r <= ide_pkg::ST_EXEC;
        act_r   <= 1'b1;
        base_r  <= idle_w ? pc_r : pc_next;
        bus_r   <= bus_of(idle_w ? pc_r : pc_next, 8'h00, 1'b1);
      end else begin
        state_r <= ide_pkg::ST_IDLE;
        act_r   <= 1'b0;
        bus_r   <= bus_of(ide_pkg::DUMMY_ADDR, 8'h00, 1'b1);
      end
    end else begin
      cyc_r <= cyc_n;
      bus_r <= nxt_bus;
      if (cyc_r == 6'h01) begin
        op_r  <= mem_rdata;
        pre_r <= (mem_rdata == ide_pkg::OP_PRE);
      end
      if (cyc_r == 6'h02 && pre_r) begin
        op_r <= mem_rdata;
      end
      if (e_cur == 6'h02) begin
        hb_r <= mem_rdata;
        lb_r <= mem_rdata;
      end
      if (is_ext && e_cur == 6'h03) begin
        lb_r <= mem_rdata;
      end
      if (mem_rd) begin
        res_r <= mem_rdata + 8'h01;
      end
    end
  end

  // programmer-visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_r   <= 8'h00;
      b_r   <= 8'h00;
      condition_code_register <= ide_pkg::RST_COND;
      x_r   <= 16'h0000;
      y_r   <= 16'h0000;
      sp_r  <= ide_pkg::RST_SP;
      pc_r  <= ide_pkg::RST_PC;
      run_r <= 1'b0;
      ill_r <= 1'b0;
    end else begin
      if (done_w) begin
        pc_r <= pc_next;
        if (acc_a_increment_op) begin
          a_r <= a_r + 8'h01;
          condition_code_register <= cond_inc(condition_code_register, a_r);
        end
        if (acc_b_increment_op) begin
          b_r <= b_r + 8'h01;
          condition_code_register <= cond_inc(condition_code_register, b_r);
        end
        if (stack_pointer_increment_op) begin
          sp_r <= sp_r + 16'h0001;
        end
        if (div_op) begin
          x_r        <= quot;
          {a_r, b_r} <= rem;
        end
      end
      if (mem_rd) begin
        condition_code_register <= cond_inc(condition_code_register, mem_rdata);
      end
      if (halt_w) begin
        pc_r <= base_r;
      end
      if (wr_cpu) begin
        case (paddr)
          ide_pkg::ADDR_ACC: {a_r, b_r} <= pwdata[15:0];
          ide_pkg::ADDR_COND: condition_code_register <= pwdata[7:0];
          ide_pkg::ADDR_X:   x_r  <= pwdata[15:0];
          ide_pkg::ADDR_Y:   y_r  <= pwdata[15:0];
          ide_pkg::ADDR_SP:  sp_r <= pwdata[15:0];
          ide_pkg::ADDR_PC:  pc_r <= pwdata[15:0];
          default: ;
        endcase
      end
      if (halt_w) begin
        run_r <= 1'b0;
      end else if (wr_w && paddr == ide_pkg::ADDR_CTRL) begin
        run_r <= pwdata[0];
      end
      ill_r <= halt_w || (ill_r && !(wr_w && paddr == ide_pkg::ADDR_STAT
                                     && pwdata[ide_pkg::STAT_ILL]));
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      ide_pkg::ADDR_CTRL: rd_val[0] = run_r;
      ide_pkg::ADDR_STAT: begin
        rd_val[ide_pkg::STAT_BUSY] = ex;
        rd_val[ide_pkg::STAT_ILL]  = ill_r;
      end
      ide_pkg::ADDR_ACC: rd_val[15:0] = {a_r, b_r};
      ide_pkg::ADDR_COND: rd_val[7:0] = condition_code_register;
      ide_pkg::ADDR_X:   rd_val[15:0] = x_r;
      ide_pkg::ADDR_Y:   rd_val[15:0] = y_r;
      ide_pkg::ADDR_SP:  rd_val[15:0] = sp_r;
      ide_pkg::ADDR_PC:  rd_val[15:0] = pc_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // two-cycle access: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc_w;
      pslverr_r <= acc_w && !hit;
      if (acc_w) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign mem_o      = bus_r;
  assign mem_active = act_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idiv_dummy_read: assert property (ex && div_op && cyc_r >= 6'h03 |->
    bus_r.addr == ide_pkg::DUMMY_ADDR && bus_r.rw) else $error("divide dummy read wrong");
  a_idiv_zero_den: assert property (done_w && div_op && x_r == 16'h0000 |=>
    x_r == ide_pkg::DIV_ZERO_Q) else $error("zero divide quotient wrong");
  a_acc_inc_sum: assert property (done_w && acc_a_increment_op |=>
    a_r == $past(a_r) + 8'h01) else $error("accumulator increment wrong");
  a_cc_upper_keep: assert property (done_w && acc_b_increment_op |=>
    condition_code_register[7:4] == $past(condition_code_register[7:4]))
    else $error("upper flags changed");
  a_carry_keep: assert property (mem_rd || (done_w && acc_a_increment_op) |=>
    $stable(condition_code_register[ide_pkg::CC_C])) else $error("carry changed");
  a_nz_flags: assert property (done_w && acc_a_increment_op |=>
    condition_code_register[ide_pkg::CC_N] == a_r[7]
    && condition_code_register[ide_pkg::CC_Z] == (a_r == 8'h00)) else $error("N or Z wrong");
  a_ovf_flag: assert property (done_w && acc_b_increment_op |=>
    condition_code_register[ide_pkg::CC_V] == ($past(b_r) == ide_pkg::OVF_OPERAND))
    else $error("overflow flag wrong");
  a_acc_two_cycles: assert property (ex && cyc_r == 6'h02 && acc_a_increment_op |->
    done_w) else $error("accumulator increment length wrong");
  a_ext_dummy_read: assert property (ex && is_ext && cyc_r == 6'h04 |=>
    bus_r.addr == ide_pkg::DUMMY_ADDR && bus_r.rw) else $error("extended dummy wrong");
  a_write_back: assert property (ex && !bus_r.rw |->
    cyc_r == ide_pkg::MEM_LAST + {5'h00, pre_r} && bus_r.addr == ea && bus_r.data == res_r)
    else $error("write back wrong");
  a_idx_dummy_read: assert property (ex && is_idx && !pre_r && cyc_r == 6'h03 |->
    bus_r.addr == ide_pkg::DUMMY_ADDR ##2 bus_r.addr == ide_pkg::DUMMY_ADDR)
    else $error("indexed dummy wrong");
  a_y_write_last: assert property (ex && pre_r && cyc_r == 6'h05 |->
    bus_r.rw ##2 !bus_r.rw && bus_r.addr == y_r + {8'h00, lb_r}) else $error("Y write wrong");
  a_sp_address: assert property (ex && stack_pointer_increment_op && cyc_r == 6'h03 |->
    bus_r.addr == sp_r && bus_r.rw) else $error("stack address wrong");
  a_sp_inc_flags: assert property (done_w && stack_pointer_increment_op |=>
    sp_r == $past(sp_r) + 16'h0001 && $stable(condition_code_register))
    else $error("stack increment wrong");
endmodule // ide_core
`default_nettype wire

//--- ide_mem_model.sv
/*
  Behavioural memory on the core's byte-wide bus: 64K bytes, zero-filled.
  Assumes registered bus cycles from the core and answers in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module ide_mem_model (
  // clock
  input  wire logic              pclk,
  // bus from the core
  input  wire ide_pkg::ide_bus_s mem_i,
  input  wire logic              mem_active,
  output logic      [7:0]        mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;
  wire  logic rd_cyc = mem_active && mem_i.rw;
  wire  logic wr_cyc = mem_active && !mem_i.rw;
  // outside a read the line changes every cycle, so no stale byte passes as data
  assign mem_rdata = rd_cyc ? mem[mem_i.addr] : ~last_r;
  initial begin
    last_r = 8'h00;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
  end
  always @(posedge pclk) begin
    last_r <= mem_rdata;
    if (wr_cyc)
      mem[mem_i.addr] <= mem_i.data;
  end
endmodule // ide_mem_model
`default_nettype wire

//--- tb_increment_divide_exec.sv
/*
  Self-checking bench for the increment/divide execution core.
  Assumes the core's APB slave and bus walk; each instruction is stopped by
  an unknown opcode 00 placed after it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_increment_divide_exec;
  localparam int          DL  = 5;
  localparam logic [15:0] PC0 = 16'h0100;
  localparam logic [15:0] FF  = 16'hFFFF;
  localparam logic [7:0]  OPC [7] = '{ide_pkg::OP_INC_ACC_A, ide_pkg::OP_INC_ACC_B,
    ide_pkg::OP_INCE, ide_pkg::OP_INCX, ide_pkg::OP_PRE, ide_pkg::OP_INC_SP, ide_pkg::OP_IDIV};
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_active;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, v;
  logic [7:0]        mem_rdata;
  logic              e;
  logic [15:0]       seed;
  ide_pkg::ide_bus_s mem_o;
  ide_pkg::ide_bus_s exp_q[$], seen_q[$];
  int                n_fail, check_count;

  ide_core #(.DIV_LAST(DL)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_o(mem_o), .mem_active(mem_active),
    .mem_rdata(mem_rdata));
  ide_mem_model mem_u (.pclk(pclk), .mem_i(mem_o), .mem_active(mem_active),
    .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(negedge pclk) begin
    if (mem_active === 1'b1)
      seen_q.push_back(mem_o);
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic timeout(input string nm);
    n_fail++;
    $display("mismatch %s expected done seen timeout", nm);
    conclude();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      timeout("apb ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic x;
    apb(1'b0, a, 32'h0000_0000, r, x);
  endtask
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [7:0] inc_cc(input logic [7:0] c, input logic [7:0] o);
    logic [7:0] s;
    s = o + 8'h01;
    c[ide_pkg::CC_N] = s[7];
    c[ide_pkg::CC_Z] = (s == 8'h00);
    c[ide_pkg::CC_V] = (o == 8'h7F);
    return c;
  endfunction
  task automatic tr(input logic [15:0] a, input logic [7:0] d = 8'h00, input logic w = 1'b1);
    exp_q.push_back({a, d, w});
  endtask

  // k picks the instruction form, j the operand corner (7F, FF, random)
  task automatic run_case(input int k, input int j);
    logic [15:0] r, x, y, sp, acc, ea, nx, xe, ae;
    logic [7:0]  op, ff, res, cc, ce;
    int          i;
    r = rnd();
    op = (j == 0) ? 8'h7F : (j == 1) ? 8'hFF : r[7:0];
    acc = rnd();
    r = rnd();
    x = (k == 6 && j == 1) ? 16'h0000 : {4'h4, r[11:0]};
    y = {4'h5, r[15:4]};
    r = rnd();
    ff = r[7:0];
    cc = r[15:8];
    ea = {4'h2, r[11:0]};
    sp = {8'hFF, op};
    nx = PC0 + 16'h0001;
    res = op + 8'h01;
    ce = inc_cc(cc, op);
    for (i = 0; i < 4; i++)
      mem_u.mem[PC0 + i] = 8'h00;
    mem_u.mem[PC0] = OPC[k];
    exp_q = {};
    tr(PC0);
    tr(PC0 + 16'h0001);
    case (k)
      0: acc[15:8] = op;
      1: acc[7:0] = op;
      2: begin
        mem_u.mem[PC0 + 1] = ea[15:8];
        mem_u.mem[PC0 + 2] = ea[7:0];
        tr(PC0 + 16'h0002);
        tr(ea);
        tr(FF);
        nx = PC0 + 16'h0003;
      end
      3: begin
        ea = x + {8'h00, ff};
        mem_u.mem[PC0 + 1] = ff;
        tr(FF);
        tr(ea);
        tr(FF);
        nx = PC0 + 16'h0002;
      end
      4: begin
        ea = y + {8'h00, ff};
        mem_u.mem[PC0 + 1] = ide_pkg::OP_INCX;
        mem_u.mem[PC0 + 2] = ff;
        tr(PC0 + 16'h0002);
        tr(FF);
        tr(ea);
        tr(FF);
        nx = PC0 + 16'h0003;
      end
      5: begin
        tr(sp);
        ce = cc;
      end
      default: begin
        for (i = 3; i <= DL; i++)
          tr(FF);
        ce = cc;
      end
    endcase
    if (k inside {[2:4]}) begin
      mem_u.mem[ea] = op;
      tr(ea, res, 1'b0);
    end
    tr(nx);
    ae = (k == 0) ? {res, acc[7:0]} : (k == 1) ? {acc[15:8], res} : acc;
    xe = x;
    if (k == 6) begin
      xe = (x == 16'h0000) ? 16'hFFFF : acc / x;
      ae = (x == 16'h0000) ? acc : acc % x;
    end
    wr(ide_pkg::ADDR_ACC, {16'h0000, acc});
    wr(ide_pkg::ADDR_COND, {24'h000000, cc});
    wr(ide_pkg::ADDR_X, {16'h0000, x});
    wr(ide_pkg::ADDR_Y, {16'h0000, y});
    wr(ide_pkg::ADDR_SP, {16'h0000, sp});
    wr(ide_pkg::ADDR_PC, {16'h0000, PC0});
    seen_q = {};
    wr(ide_pkg::ADDR_CTRL, 32'h0000_0001);
    for (i = 0; i < 200 && !(seen_q.size() >= exp_q.size() && mem_active === 1'b0); i++)
      @(negedge pclk);
    if (i >= 200)
      timeout("instruction end");
    chk("bus cycles", 32'(seen_q.size()), 32'(exp_q.size()));
    for (i = 0; i < exp_q.size() && i < seen_q.size(); i++) begin
      chk("bus addr", {16'h0000, seen_q[i].addr}, {16'h0000, exp_q[i].addr});
      chk("bus rw", {31'h0, seen_q[i].rw}, {31'h0, exp_q[i].rw});
      if (exp_q[i].rw == 1'b0)
        chk("bus data", {24'h000000, seen_q[i].data}, {24'h000000, exp_q[i].data});
    end
    if (k inside {[2:4]})
      chk("memory", {24'h000000, mem_u.mem[ea]}, {24'h000000, res});
    rd(ide_pkg::ADDR_ACC, v);
    chk("acc", v, {16'h0000, ae});
    rd(ide_pkg::ADDR_COND, v);
    chk("cond codes", v, {24'h000000, ce});
    rd(ide_pkg::ADDR_X, v);
    chk("x", v, {16'h0000, xe});
    rd(ide_pkg::ADDR_SP, v);
    chk("sp", v, {16'h0000, (k == 5) ? sp + 16'h0001 : sp});
    rd(ide_pkg::ADDR_PC, v);
    chk("pc", v, {16'h0000, nx});
    rd(ide_pkg::ADDR_STAT, v);
    chk("status", v, 32'h0000_0002);
    wr(ide_pkg::ADDR_STAT, 32'h0000_0002);
    $display("test kind %0d case %0d done", k, j);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    seed = 16'h0022;
    n_fail = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ide_pkg::ADDR_COND, v);
    chk("reset cond codes", v, 32'h0000_0000);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF, v, e);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    apb(1'b0, 12'h00A, 32'h0000_0000, v, e);
    chk("misaligned err", {31'h0, e}, 32'h0000_0001);
    chk("misaligned data", v, 32'h0000_0000);
    $display("test apb refusal done");
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 3; j++)
        run_case(k, j);
    end
    conclude();
  end
endmodule // tb_increment_divide_exec
`default_nettype wire
